//--- bench/adc_core_model.sv
`timescale 1ns/1ps
module adc_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] mux_sel,
  input wire logic conv_run,
  input wire logic [11:0] level_in,
  output logic [11:0] adc_result
);
  // Outside a conversion the code toggles every cycle, so a result taken late shows up wrong.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_result <= 12'hA5A;
    end else if (conv_run) begin
      adc_result <= level_in + {9'h000, mux_sel};
    end else begin
      adc_result <= ~adc_result;
    end
  end
endmodule : adc_core_model

//--- bench/sar_adc_channel_sequencer_tb.sv
`timescale 1ns/1ps
module sar_adc_channel_sequencer_tb;
  import sar_seq_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic deep_sleep = 1'b0;
  logic [11:0] level_in = 12'h100;
  wire logic [31:0] hrdata;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [11:0] adc_result;
  wire logic [2:0] mux_sel;
  wire logic sample_hold;
  wire logic conv_run;
  wire logic irq;
  int bad_count = 0;
  int check_count = 0;

  always #50 hclk = ~hclk;

  sar_adc_channel_sequencer u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .deep_sleep(deep_sleep),
    .adc_result(adc_result), .mux_sel(mux_sel), .sample_hold(sample_hold),
    .conv_run(conv_run), .irq(irq)
  );

  adc_core_model u_core (
    .hclk(hclk), .hresetn(hresetn), .mux_sel(mux_sel), .conv_run(conv_run),
    .level_in(level_in), .adc_result(adc_result)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task stop_test;
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(what, exp, x);
    check("hresp", 32'h0, {31'h0, hresp});
  endtask : rd_chk

  // Positioned at an edge whose ended cycle was the first sampling cycle of the slot.
  task slot(input logic [2:0] ch, input int smp);
    int n;
    for (n = 0; sample_hold === 1'b1 && n < 300; n++) begin
      check("mux_sel", {29'h0, ch}, {29'h0, mux_sel});
      @(posedge hclk);
    end
    check("sample cycles", 32'(smp), 32'(n));
    for (n = 0; conv_run === 1'b1 && n < 300; n++) @(posedge hclk);
    check("conv cycles", 32'(CONV_CYCLES), 32'(n));
    check("no gap", 32'h1, {31'h0, sample_hold});
  endtask : slot

  task fw_conv(input logic [2:0] ch, input logic [11:0] lvl, input logic [31:0] stat,
               input logic exp_irq);
    int n;
    level_in <= lvl;
    wr(OFS_CTRL, 32'h7 | {25'h0, ch, 4'h0});
    for (n = 0; conv_run !== 1'b1 && n < 300; n++) @(posedge hclk);
    check("fw mux_sel", {29'h0, ch}, {29'h0, mux_sel});
    for (n = 0; conv_run === 1'b1 && n < 300; n++) @(posedge hclk);
    repeat (2) @(posedge hclk);
    check("irq", {31'h0, exp_irq}, {31'h0, irq});
    check("single conversion", 32'h0, {31'h0, sample_hold});
    rd_chk("result", OFS_RES_BASE + {3'h0, ch, 2'h0}, {20'h0, lvl + {9'h0, ch}});
    rd_chk("int_stat", OFS_INT_STAT, stat);
    wr(OFS_INT_STAT, 32'h7);
  endtask : fw_conv

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task reset_values;
    rd_chk("chen", OFS_CHEN, 32'h0);
    rd_chk("limit_lo", OFS_LIMIT_LO, 32'h0);
    rd_chk("limit_hi", OFS_LIMIT_HI, 32'hFFF);
    rd_chk("sample time", OFS_SMP_BASE + 8'h1C, 32'h4);
    rd_chk("int_mask", OFS_INT_MASK, 32'h0);
    wr(OFS_STATUS, 32'h77);
    rd_chk("status", OFS_STATUS, 32'h1);
    wr(8'hFC, 32'hFFFFFFFF);
    rd_chk("unmapped", 8'hFC, 32'h0);
  endtask : reset_values

  task hw_scan;
    int n;
    wr(OFS_SMP_BASE, 32'h0);
    wr(OFS_SMP_BASE + 8'h08, 32'h3);
    wr(OFS_CHEN, 32'h5);
    wr(OFS_CTRL, 32'h1);
    for (n = 0; sample_hold !== 1'b1 && n < 10; n++) @(posedge hclk);
    slot(3'h0, 1);
    slot(3'h2, 3);
    slot(3'h0, 1);
    wr(OFS_CTRL, 32'h0);
    rd_chk("scan int_stat", OFS_INT_STAT, 32'h6);
    rd_chk("result ch0", OFS_RES_BASE, 32'h100);
    rd_chk("result ch2", OFS_RES_BASE + 8'h08, 32'h102);
    rd_chk("result ch1", OFS_RES_BASE + 8'h04, 32'h0);
    wr(OFS_INT_STAT, 32'h7);
    rd_chk("cleared", OFS_INT_STAT, 32'h0);
  endtask : hw_scan

  task window_cases;
    wr(OFS_LIMIT_LO, 32'h200);
    wr(OFS_LIMIT_HI, 32'h300);
    wr(OFS_INT_MASK, 32'h1);
    fw_conv(3'h0, 12'h3FF, 32'h3, 1'b1);
    fw_conv(3'h0, 12'h300, 32'h2, 1'b0);
    fw_conv(3'h3, 12'h1FC, 32'h3, 1'b1);
    fw_conv(3'h5, 12'h1FB, 32'h2, 1'b0);
    wr(OFS_INT_MASK, 32'h0);
    fw_conv(3'h1, 12'h000, 32'h3, 1'b0);
  endtask : window_cases

  task sleep_abort;
    int n;
    level_in <= 12'h0AB;
    wr(OFS_CHEN, 32'h80);
    wr(OFS_CTRL, 32'h1);
    for (n = 0; conv_run !== 1'b1 && n < 300; n++) @(posedge hclk);
    check("conv before sleep", 32'h1, {31'h0, conv_run});
    deep_sleep <= 1'b1;
    repeat (2) @(posedge hclk);
    check("sleep conv_run", 32'h0, {31'h0, conv_run});
    repeat (25) @(posedge hclk);
    check("sleep sample_hold", 32'h0, {31'h0, sample_hold});
    rd_chk("sleep result", OFS_RES_BASE + 8'h1C, 32'h0);
    wr(OFS_CTRL, 32'h0);
    deep_sleep <= 1'b0;
  endtask : sleep_abort

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    reset_values();
    hw_scan();
    window_cases();
    sleep_abort();
    stop_test();
  end

  // The whole sequence needs well under two thousand cycles.
  initial begin
    #2000000;
    bad_count++;
    stop_test();
  end
endmodule : sar_adc_channel_sequencer_tb

//--- core/result_mem.sv
`timescale 1ns/1ps
module result_mem (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [11:0] wdata,
  input wire logic [2:0] raddr,
  output logic [11:0] rdata
);
  import sar_seq_pkg::*;

  logic [11:0] mem_ff [N_CH];
  logic [11:0] rdata_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < N_CH; i++) begin
        mem_ff[i] <= 12'h000;
      end
      rdata_ff <= 12'h000;
    end else begin
      if (we) begin
        mem_ff[waddr] <= wdata; // [RULE12]
      end
      rdata_ff <= mem_ff[raddr];
    end
  end

  assign rdata = rdata_ff;

  property p_store;
    @(posedge hclk) disable iff (!hresetn)
    we |=> mem_ff[$past(waddr)] == $past(wdata);
  endproperty
  a_store: assert property (p_store) else $error("result not stored"); // [RULE5]

endmodule : result_mem

//--- core/sar_adc_channel_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1: Conversion lasts eighteen clocks; clock within limit.
// RULE2: Scan enabled channels of eight without CPU.
// RULE3: Next sample follows conversion with no gap.
// RULE4: Hardware scan or firmware picks each channel.
// RULE5: Each channel keeps its own result buffer.
// RULE6: Each channel has its own sample time.
// RULE7: Results outside low/high window raise interrupt.
// RULE8: Out-of-range flag set at conversion end.
// RULE9: Sample-and-hold aperture length is programmable.
// RULE10: Deep sleep halts converter and sequencer.
// RULE11: Ascending channel order, wrapping to lowest.
// RULE12: Full twelve-bit result, overwritten by next.
module sar_adc_channel_sequencer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic deep_sleep,
  input wire logic [sar_seq_pkg::RES_W-1:0] adc_result,
  output logic [2:0] mux_sel,
  output logic sample_hold,
  output logic conv_run,
  output logic irq
);
  import sar_seq_pkg::*;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic [7:0] addr_ff;
  logic hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] rd_mux;

  wire addr_take = hsel & hready & htrans[1];
  wire [7:0] ofs = addr_ff;
  wire is_smp = (ofs[7:5] == OFS_SMP_BASE[7:5]);
  wire is_res = (ofs[7:5] == OFS_RES_BASE[7:5]);
  wire w_ctrl = wr_pend_ff && (ofs == OFS_CTRL);
  wire w_chen = wr_pend_ff && (ofs == OFS_CHEN);
  wire w_int = wr_pend_ff && (ofs == OFS_INT_STAT);
  wire w_mask = wr_pend_ff && (ofs == OFS_INT_MASK);
  wire w_lo = wr_pend_ff && (ofs == OFS_LIMIT_LO);
  wire w_hi = wr_pend_ff && (ofs == OFS_LIMIT_HI);
  wire w_smp = wr_pend_ff && is_smp;

  // Reads take one wait state so that result words can come from the
  // registered memory output; writes complete with no wait state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
      hreadyout_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= addr_take & hwrite;
      rd_pend_ff <= addr_take & ~hwrite;
      if (addr_take) begin
        addr_ff <= haddr[7:0];
      end
      hreadyout_ff <= ~(addr_take & ~hwrite);
      if (rd_pend_ff) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic en_ff;
  logic fw_mode_ff;
  logic [2:0] fw_chan_ff;
  logic start_req_ff;
  logic [7:0] chen_ff;
  logic [2:0] int_stat_ff;
  logic [2:0] int_mask_ff;
  logic [11:0] lim_lo_ff;
  logic [11:0] lim_hi_ff;
  logic [7:0] smp_ff [N_CH];
  logic take_start;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_ff <= 1'b0;
      fw_mode_ff <= 1'b0;
      fw_chan_ff <= 3'h0;
      chen_ff <= RST_CHEN;
      int_mask_ff <= 3'h0;
      lim_lo_ff <= RST_LIMIT_LO;
      lim_hi_ff <= RST_LIMIT_HI;
      for (int i = 0; i < N_CH; i++) begin
        smp_ff[i] <= RST_SMP;
      end
    end else begin
      if (w_ctrl) begin
        en_ff <= hwdata[CTRL_EN_BIT];
        fw_mode_ff <= hwdata[CTRL_FW_BIT]; // [RULE4]
        fw_chan_ff <= hwdata[CTRL_FWCH_LSB +: 3];
      end
      if (w_chen) begin
        chen_ff <= hwdata[7:0];
      end
      if (w_mask) begin
        int_mask_ff <= hwdata[2:0];
      end
      if (w_lo) begin
        lim_lo_ff <= hwdata[11:0]; // [RULE7]
      end
      if (w_hi) begin
        lim_hi_ff <= hwdata[11:0]; // [RULE7]
      end
      if (w_smp) begin
        smp_ff[ofs[4:2]] <= hwdata[7:0]; // [RULE6] [RULE9]
      end
    end
  end

  // A firmware start request waits here until the sequencer takes it;
  // a new request in the same cycle as the take is kept.
  wire start_wr = w_ctrl && hwdata[CTRL_START_BIT] && hwdata[CTRL_FW_BIT];
  wire nxt_start_req = start_wr | (start_req_ff & ~take_start);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_req_ff <= 1'b0;
    end else begin
      start_req_ff <= nxt_start_req; // [RULE4]
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  seq_state_e state_ff;
  seq_state_e nxt_state;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [2:0] ch_ff;
  logic [2:0] nxt_ch;

  // The converter clock is the bus clock; a faster clock disables the block.
  wire active = en_ff & ~deep_sleep & CLK_OK; // [RULE1] [RULE10]
  wire [2:0] scan_ch = next_chan(ch_ff, chen_ff); // [RULE11]
  wire [2:0] first_ch = next_chan(3'h7, chen_ff); // [RULE11]
  wire [2:0] hw_ch = (state_ff == ST_IDLE) ? first_ch : scan_ch;
  wire [2:0] go_ch = fw_mode_ff ? fw_chan_ff : hw_ch;
  wire can_go = fw_mode_ff ? start_req_ff : (chen_ff != 8'h00); // [RULE2]
  wire cnt_last = (cnt_ff == 8'h01);
  wire conv_end = (state_ff == ST_CONV) && cnt_last && active;
  wire [7:0] go_smp = smp_cycles(smp_ff[go_ch]); // [RULE6]

  // A finished conversion goes straight into the next sample, so channel
  // changes cost no slot.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_ch = ch_ff;
    take_start = 1'b0;
    if (!active) begin
      nxt_state = ST_IDLE; // [RULE10]
      nxt_cnt = 8'h00;
    end else begin
      case (state_ff)
        ST_IDLE, ST_CONV: begin
          if (state_ff == ST_CONV && !cnt_last) begin
            nxt_cnt = cnt_ff - 8'h01; // [RULE1]
          end else if (can_go) begin
            nxt_state = ST_SAMPLE; // [RULE3] [RULE2]
            nxt_ch = go_ch;
            nxt_cnt = go_smp; // [RULE9]
            take_start = fw_mode_ff;
          end else begin
            nxt_state = ST_IDLE;
            nxt_cnt = 8'h00;
          end
        end
        ST_SAMPLE: begin
          if (cnt_last) begin
            nxt_state = ST_CONV;
            nxt_cnt = CONV_CYCLES; // [RULE1]
          end else begin
            nxt_cnt = cnt_ff - 8'h01; // [RULE6]
          end
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_cnt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 8'h00;
      ch_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      ch_ff <= nxt_ch;
    end
  end

  assign mux_sel = ch_ff;
  assign sample_hold = state_ff[1];
  assign conv_run = state_ff[2];

  // ----------------------------------------------------------------
  // Results, window check and interrupts
  // ----------------------------------------------------------------
  logic [11:0] mem_rdata;
  logic out_of_range;
  logic irq_ff;

  result_mem u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .we(conv_end), // [RULE5]
    .waddr(ch_ff),
    .wdata(adc_result),
    .raddr(haddr[4:2]),
    .rdata(mem_rdata)
  );

  window_check u_win (
    .value(adc_result),
    .lim_lo(lim_lo_ff),
    .lim_hi(lim_hi_ff),
    .out_of_range(out_of_range)
  );

  // A scan is complete when the next channel does not lie above this one.
  wire scan_evt = conv_end && !fw_mode_ff && (scan_ch <= ch_ff);
  wire range_evt = conv_end && out_of_range; // [RULE8]
  wire [2:0] int_evt = {scan_evt, conv_end, range_evt};
  wire [2:0] int_clr = w_int ? hwdata[2:0] : 3'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat_ff <= 3'h0;
      irq_ff <= 1'b0;
    end else begin
      int_stat_ff <= int_evt | (int_stat_ff & ~int_clr); // [RULE7] [RULE8]
      irq_ff <= |(int_stat_ff & int_mask_ff);
    end
  end

  assign irq = irq_ff;

  // ----------------------------------------------------------------
  // Read selection
  // ----------------------------------------------------------------
  wire [31:0] ctrl_rd = {25'h0, fw_chan_ff, 1'b0, start_req_ff, fw_mode_ff, en_ff};
  wire [31:0] stat_rd = {25'h0, ch_ff, 1'b0, state_ff};

  assign rd_mux = (ofs == OFS_CTRL) ? ctrl_rd :
                  (ofs == OFS_CHEN) ? {24'h0, chen_ff} :
                  (ofs == OFS_STATUS) ? stat_rd :
                  (ofs == OFS_INT_STAT) ? {29'h0, int_stat_ff} :
                  (ofs == OFS_INT_MASK) ? {29'h0, int_mask_ff} :
                  (ofs == OFS_LIMIT_LO) ? {20'h0, lim_lo_ff} :
                  (ofs == OFS_LIMIT_HI) ? {20'h0, lim_hi_ff} :
                  is_smp ? {24'h0, smp_ff[ofs[4:2]]} :
                  is_res ? {20'h0, mem_rdata} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [4:0] conv_len_ff;
  logic [7:0] smp_len_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_len_ff <= 5'h00;
      smp_len_ff <= 8'h00;
    end else begin
      conv_len_ff <= (state_ff == ST_CONV) ? 5'(conv_len_ff + 5'h01) : 5'h00;
      smp_len_ff <= (state_ff == ST_SAMPLE) ? 8'(smp_len_ff + 8'h01) : 8'h00;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_conv_len;
    conv_end |-> conv_len_ff == 5'h11;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // [RULE1]

  property p_no_gap;
    conv_end && can_go |=> sample_hold && !conv_run;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("idle slot after conversion"); // [RULE3]

  property p_scan_order;
    conv_end && !fw_mode_ff && !w_ctrl && !w_chen |=>
      mux_sel == next_chan($past(mux_sel), chen_ff) && chen_ff[mux_sel];
  endproperty
  a_scan_order: assert property (p_scan_order) else $error("scan order wrong"); // [RULE11]

  property p_fw_chan;
    $rose(sample_hold) && fw_mode_ff && $past(fw_mode_ff) |-> mux_sel == $past(fw_chan_ff);
  endproperty
  a_fw_chan: assert property (p_fw_chan) else $error("firmware channel ignored"); // [RULE4]

  property p_smp_len;
    state_ff == ST_SAMPLE && nxt_state == ST_CONV && !w_smp |->
      8'(smp_len_ff + 8'h01) == smp_cycles(smp_ff[ch_ff]);
  endproperty
  a_smp_len: assert property (p_smp_len) else $error("sample time wrong"); // [RULE6]

  property p_range;
    conv_end && ((adc_result < lim_lo_ff) || (adc_result > lim_hi_ff)) |=>
      int_stat_ff[INT_RANGE_BIT] ##1 (irq || !int_mask_ff[INT_RANGE_BIT]);
  endproperty
  a_range: assert property (p_range) else $error("range event lost"); // [RULE8]

  property p_sleep;
    deep_sleep |=> !sample_hold && !conv_run;
  endproperty
  a_sleep: assert property (p_sleep) else $error("active in deep sleep"); // [RULE10]

  property p_start_kept;
    start_req_ff && fw_mode_ff && active && state_ff == ST_IDLE |=>
      sample_hold && mux_sel == $past(fw_chan_ff);
  endproperty
  a_start_kept: assert property (p_start_kept) else $error("start request lost"); // [RULE4]

  c_scan_wrap: cover property (scan_evt);
  c_fw_conv: cover property (conv_end && fw_mode_ff);
  c_range: cover property (range_evt ##2 irq);

endmodule : sar_adc_channel_sequencer

//--- core/window_check.sv
`timescale 1ns/1ps
module window_check (
  input wire logic [11:0] value,
  input wire logic [11:0] lim_lo,
  input wire logic [11:0] lim_hi,
  output logic out_of_range
);

  // Values equal to a limit are inside the window.
  assign out_of_range = (value < lim_lo) || (value > lim_hi); // [RULE7]

endmodule : window_check

//--- inc/sar_seq_pkg.sv
package sar_seq_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int unsigned N_CH = 8;
  localparam int unsigned RES_W = 12;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned ADC_CLK_MAX_HZ = 18_000_000;
  localparam bit CLK_OK = (CLK_HZ <= ADC_CLK_MAX_HZ);
  localparam logic [7:0] CONV_CYCLES = 8'h12;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHEN = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  localparam logic [7:0] OFS_LIMIT_LO = 8'h14;
  localparam logic [7:0] OFS_LIMIT_HI = 8'h18;
  localparam logic [7:0] OFS_SMP_BASE = 8'h20;
  localparam logic [7:0] OFS_RES_BASE = 8'h40;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_FW_BIT = 1;
  localparam int unsigned CTRL_START_BIT = 2;
  localparam int unsigned CTRL_FWCH_LSB = 4;
  localparam int unsigned INT_RANGE_BIT = 0;
  localparam int unsigned INT_CONV_BIT = 1;
  localparam int unsigned INT_SCAN_BIT = 2;
  localparam logic [7:0] RST_CHEN = 8'h00;
  localparam logic [11:0] RST_LIMIT_LO = 12'h000;
  localparam logic [11:0] RST_LIMIT_HI = 12'hFFF;
  localparam logic [7:0] RST_SMP = 8'h04;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SAMPLE = 3'h2,
    ST_CONV = 3'h4
  } seq_state_e;

  // Next enabled channel above cur, wrapping; cur itself if it is the only one.
  function automatic logic [2:0] next_chan(input logic [2:0] cur, input logic [7:0] en);
    logic [2:0] idx;
    logic [2:0] res;
    logic found;
    res = cur;
    found = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      idx = 3'(cur + 3'(i));
      if (!found && en[idx]) begin
        res = idx;
        found = 1'b1;
      end
    end
    return res;
  endfunction : next_chan

  // A programmed sample time of zero still samples for one cycle.
  function automatic logic [7:0] smp_cycles(input logic [7:0] st);
    return (st == 8'h00) ? 8'h01 : st;
  endfunction : smp_cycles

endpackage : sar_seq_pkg
